// ==== src/plci_top.sv ====
// Port registers, output latches and interrupt-on-change logic.
`timescale 1ns/1ps
module plci_top
  import plci_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  input  wire logic       reg_rd_done,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] pin_dir_in,
  input  wire logic [7:0] change_enable_mask,
  input  wire logic [7:0] default_value_register,
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  output logic            irq_o,
  output logic            irq_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]    latch_q;
  logic [7:0]    capture_q;
  logic [7:0]    cmp_sel_q;
  plci_irq_cfg_t irq_cfg_q;
  logic [7:0]    flag_q;
  logic [7:0]    flag_d;
  logic          int_q;
  logic          int_d;
  logic [7:0]    rdata_q;
  logic [7:0]    rd_addr_q;
  logic [7:0]    rd_mux;
  logic [7:0]    cond;
  logic [7:0]    cfg_byte;
  plci_chg_cfg_t chg_cfg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_latch  = reg_wr & ((reg_addr == PLCI_ADDR_LATCH) | (reg_addr == PLCI_ADDR_PORT));
  wire wr_cmp    = reg_wr & (reg_addr == PLCI_ADDR_CMP_SEL);
  wire wr_cfg    = reg_wr & (reg_addr == PLCI_ADDR_DEV_CFG);
  wire clr_read  = reg_rd_done &
                   ((rd_addr_q == PLCI_ADDR_CAPTURE) | (rd_addr_q == PLCI_ADDR_PORT));
  wire any_cond  = |cond;
  wire new_event = any_cond & (~int_q | clr_read);

  assign cfg_byte = {5'b0_0000, irq_cfg_q.open_drain_select, irq_cfg_q.pol, 1'b0};
  assign chg_cfg  = '{dir_in: pin_dir_in, en: change_enable_mask,
                      sel: cmp_sel_q, def: default_value_register};

  assign rd_mux = (reg_addr == PLCI_ADDR_PORT)    ? pin_in    :
                  (reg_addr == PLCI_ADDR_LATCH)   ? latch_q   :
                  (reg_addr == PLCI_ADDR_CAPTURE) ? capture_q :
                  (reg_addr == PLCI_ADDR_FLAG)    ? flag_q    :
                  (reg_addr == PLCI_ADDR_CMP_SEL) ? cmp_sel_q :
                  (reg_addr == PLCI_ADDR_DEV_CFG) ? cfg_byte  : PLCI_RST_BYTE;

  plci_change_detect u_detect (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  (pin_in),
    .cfg     (chg_cfg),
    .cond    (cond)
  );

  // ----------------------------------------------------------------
  // Interrupt state
  // ----------------------------------------------------------------
  // only a delivered read clears; a set in the same cycle wins.
  assign int_d  = new_event | (int_q & ~clr_read);
  // conditions accumulate; default-mode mismatches re-set at once.
  assign flag_d = (flag_q & {8{~clr_read}}) | cond;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_q  <= 1'b0;
      flag_q <= PLCI_RST_BYTE;
    end else begin
      int_q  <= int_d;
      flag_q <= flag_d;
    end
  end

  // capture only on a new event
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      capture_q <= PLCI_RST_BYTE;
    end else if (new_event) begin
      capture_q <= pin_in;
    end
  end

  // ----------------------------------------------------------------
  // Registers written by the host
  // ----------------------------------------------------------------
  // port and latch writes share the latch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      latch_q <= PLCI_RST_BYTE;
    end else if (wr_latch) begin
      latch_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_sel_q <= PLCI_RST_BYTE;
      irq_cfg_q <= '0;
    end else begin
      if (wr_cmp) begin
        cmp_sel_q <= reg_wdata;
      end
      if (wr_cfg) begin
        irq_cfg_q.open_drain_select <= reg_wdata[PLCI_ODR_BIT];
        irq_cfg_q.pol <= reg_wdata[PLCI_POL_BIT];
      end
    end
  end

  // Read data is held until the next read so the transport may take it late.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q   <= PLCI_RST_BYTE;
      rd_addr_q <= PLCI_RST_BYTE;
    end else if (reg_rd) begin
      rdata_q   <= rd_mux;
      rd_addr_q <= reg_addr;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_q;
  assign pin_out   = latch_q;
  assign pin_oe    = ~pin_dir_in;
  // open-drain pulls low only; push-pull follows polarity
  assign irq_o     = irq_cfg_q.open_drain_select ? 1'b0 : ~(int_q ^ irq_cfg_q.pol);
  assign irq_oe    = irq_cfg_q.open_drain_select ? int_q : 1'b1;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_capture_on_event;
    @(posedge clk) disable iff (sys_rst)
    (!int_q && any_cond) |=> (capture_q == $past(pin_in)) && int_q;
  endproperty
  a_capture_on_event: assert property (p_capture_on_event)
    else $error("capture not taken on interrupt event");

  property p_capture_holds;
    @(posedge clk) disable iff (sys_rst)
    (int_q && !clr_read) |=> $stable(capture_q);
  endproperty
  a_capture_holds: assert property (p_capture_holds)
    else $error("capture changed while interrupt pending");

  property p_port_read;
    @(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == PLCI_ADDR_PORT) |=> reg_rdata == $past(pin_in);
  endproperty
  a_port_read: assert property (p_port_read)
    else $error("port read did not return pin levels");

  property p_port_write;
    @(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == PLCI_ADDR_PORT) |=> latch_q == $past(reg_wdata);
  endproperty
  a_port_write: assert property (p_port_write)
    else $error("port write did not reach latch");

  property p_latch_read;
    @(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == PLCI_ADDR_LATCH && !reg_wr) |=> reg_rdata == $past(latch_q);
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("latch read did not return latch contents");

  property p_latch_drive;
    @(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == PLCI_ADDR_LATCH) |=> pin_out == $past(reg_wdata);
  endproperty
  a_latch_drive: assert property (p_latch_drive)
    else $error("latch write did not drive pins");

  property p_irq_pin;
    @(posedge clk) disable iff (sys_rst)
    (!irq_cfg_q.open_drain_select) |-> (irq_oe && irq_o == (int_q == irq_cfg_q.pol));
  endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("push-pull interrupt level wrong");

  property p_outputs_quiet;
    @(posedge clk) disable iff (sys_rst)
    (!int_q && (change_enable_mask & pin_dir_in) == PLCI_RST_BYTE) |=> !int_q;
  endproperty
  a_outputs_quiet: assert property (p_outputs_quiet)
    else $error("interrupt raised with no enabled input");

  property p_clear_on_read;
    @(posedge clk) disable iff (sys_rst)
    (int_q && clr_read && !any_cond) |=> !int_q;
  endproperty
  a_clear_on_read: assert property (p_clear_on_read)
    else $error("delivered read did not clear interrupt");

  property p_write_no_clear;
    @(posedge clk) disable iff (sys_rst)
    (int_q && !clr_read) |=> int_q;
  endproperty
  a_write_no_clear: assert property (p_write_no_clear)
    else $error("interrupt dropped without a delivered read");

  property p_default_persists;
    @(posedge clk) disable iff (sys_rst)
    (int_q && clr_read && (cond & cmp_sel_q) != PLCI_RST_BYTE) |=> int_q;
  endproperty
  a_default_persists: assert property (p_default_persists)
    else $error("default mismatch lost after read");

  property p_flag_tracks;
    @(posedge clk) disable iff (sys_rst)
    any_cond |=> (flag_q & $past(cond)) == $past(cond);
  endproperty
  a_flag_tracks: assert property (p_flag_tracks)
    else $error("flag missing a pin condition");

  property p_open_drain;
    @(posedge clk) disable iff (sys_rst)
    irq_cfg_q.open_drain_select |-> (!irq_o && irq_oe == int_q);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain interrupt drive wrong");

  property p_no_recapture;
    @(posedge clk) disable iff (sys_rst)
    (int_q && !clr_read && any_cond) |=> int_q && $stable(capture_q);
  endproperty
  a_no_recapture: assert property (p_no_recapture)
    else $error("later change restarted interrupt or recaptured port");

  property p_prev_toggle;
    @(posedge clk) disable iff (sys_rst)
    (!int_q && !$past(sys_rst) &&
     ((pin_in ^ $past(pin_in)) & change_enable_mask & pin_dir_in & ~cmp_sel_q)
       != PLCI_RST_BYTE) |=> int_q;
  endproperty
  a_prev_toggle: assert property (p_prev_toggle)
    else $error("previous-value toggle did not interrupt");

  property p_prev_settles;
    @(posedge clk) disable iff (sys_rst)
    (!int_q && !$past(sys_rst) && cmp_sel_q == PLCI_RST_BYTE && pin_in == $past(pin_in))
    |=> !int_q;
  endproperty
  a_prev_settles: assert property (p_prev_settles)
    else $error("steady pins interrupted in previous-value mode");

  property p_default_mismatch;
    @(posedge clk) disable iff (sys_rst)
    (!int_q && !$past(sys_rst) &&
     ((pin_in ^ default_value_register) & change_enable_mask & pin_dir_in & cmp_sel_q)
       != PLCI_RST_BYTE) |=> int_q;
  endproperty
  a_default_mismatch: assert property (p_default_mismatch)
    else $error("default mismatch did not interrupt");

  property p_mode_select;
    @(posedge clk) disable iff (sys_rst)
    (!int_q &&
     ((pin_in ^ default_value_register) & change_enable_mask & pin_dir_in & cmp_sel_q)
       == PLCI_RST_BYTE &&
     ((pin_in ^ $past(pin_in)) & change_enable_mask & pin_dir_in & ~cmp_sel_q)
       == PLCI_RST_BYTE) |=> !int_q;
  endproperty
  a_mode_select: assert property (p_mode_select)
    else $error("interrupt raised with no condition in the selected mode");

  property p_clear_waits;
    @(posedge clk) disable iff (sys_rst)
    (int_q && !clr_read && reg_rd &&
     (reg_addr == PLCI_ADDR_CAPTURE || reg_addr == PLCI_ADDR_PORT)) |=> int_q;
  endproperty
  a_clear_waits: assert property (p_clear_waits)
    else $error("interrupt cleared before the read byte was delivered");

endmodule

// ==== src/plci_pkg.sv ====
// Shared constants and types for the port latch and change interrupt block.
package plci_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PLCI_ADDR_CMP_SEL  = 8'h04;
  localparam logic [7:0] PLCI_ADDR_DEV_CFG  = 8'h05;
  localparam logic [7:0] PLCI_ADDR_FLAG     = 8'h07;
  localparam logic [7:0] PLCI_ADDR_CAPTURE  = 8'h08;
  localparam logic [7:0] PLCI_ADDR_PORT     = 8'h09;
  localparam logic [7:0] PLCI_ADDR_LATCH    = 8'h0A;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         PLCI_ODR_BIT       = 2;
  localparam int         PLCI_POL_BIT       = 1;
  localparam int         PLCI_WIDTH         = 8;
  localparam logic [7:0] PLCI_RST_BYTE      = 8'h00;
  localparam logic [7:0] PLCI_CFG_MASK      = 8'h06;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic open_drain_select;
    logic pol;
  } plci_irq_cfg_t;

  typedef struct packed {
    logic [7:0] dir_in;
    logic [7:0] en;
    logic [7:0] sel;
    logic [7:0] def;
  } plci_chg_cfg_t;

endpackage

// ==== src/plci_change_detect.sv ====
// Per-pin change detection against the previous level or a default value.
`timescale 1ns/1ps
module plci_change_detect
  import plci_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic [7:0]    pin_in,
  input  wire plci_chg_cfg_t cfg,
  output logic      [7:0]    cond
);

  logic [7:0] ref_q;
  logic       primed_q;

  // The reference is meaningless before the first sampled level, so
  // detection waits one cycle after reset to avoid a false event.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Per-pin comparison
  // ----------------------------------------------------------------
  genvar i;
  for (i = 0; i < PLCI_WIDTH; i++) begin : g_pin
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        ref_q[i] <= 1'b0;
      end else begin
        ref_q[i] <= pin_in[i];
      end
    end
    assign cond[i] = primed_q & cfg.en[i] & cfg.dir_in[i] &
                     (cfg.sel[i] ? (pin_in[i] ^ cfg.def[i]) : (pin_in[i] ^ ref_q[i]));
  end

endmodule

// ==== testbench/plci_host.sv ====
// Host model that issues single-byte register reads and writes.
`timescale 1ns/1ps
module plci_host (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  output logic            reg_rd_done,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    reg_rd_done = 1'b0;
  end

  // Released address and data are inverted so a stale value never looks live.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, input logic dlv, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    reg_rd_done = dlv;
    @(negedge clk);
    reg_rd_done = 1'b0;
  endtask
endmodule

// ==== testbench/plci_top_tb.sv ====
// Self-checking bench for the port latch and change interrupt block.
`timescale 1ns/1ps
module plci_top_tb;
  import plci_pkg::*;
  logic       clk = 1'b0;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic       reg_rd_done;
  logic [7:0] reg_rdata;
  logic [7:0] pin_dir_in;
  logic [7:0] change_enable_mask;
  logic [7:0] default_value_register;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic       irq_o;
  logic       irq_oe;
  logic [7:0] cfg_v;
  int         fail_count = 0;
  int         comparisons = 0;

  always #2.5 clk = ~clk;

  plci_top plci_top_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rd_done(reg_rd_done),
    .reg_rdata(reg_rdata), .pin_dir_in(pin_dir_in), .change_enable_mask(change_enable_mask),
    .default_value_register(default_value_register), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq_o(irq_o), .irq_oe(irq_oe));
  plci_host plci_host_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rd_done(reg_rd_done), .reg_rdata(reg_rdata));

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Open drain ignores polarity; push-pull drives the active level given by polarity.
  function automatic logic [7:0] irq_exp(input logic act);
    if (cfg_v[PLCI_ODR_BIT]) return {6'h00, 1'b0, act};
    return {6'h00, cfg_v[PLCI_POL_BIT] ? act : ~act, 1'b1};
  endfunction

  task automatic chk_irq(input logic act);
    chk("irq", {6'h00, irq_o, irq_oe}, irq_exp(act));
  endtask

  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    finish_test();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] p;
    logic [7:0] e;
    int         k;
    int         j;
    cfg_v = 8'h00;
    sys_rst = 1'b1;
    pin_dir_in = 8'hFF;
    change_enable_mask = 8'h00;
    default_value_register = 8'h00;
    pin_in = 8'h00;
    void'($urandom(64));
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    plci_host_inst.read_reg(PLCI_ADDR_LATCH, 1'b1, d);
    chk("latch_rst", d, PLCI_RST_BYTE);
    chk_irq(1'b0);
    // --------------------------------------------------------------
    // Latch and port access, interrupts masked
    // --------------------------------------------------------------
    for (k = 0; k < 6; k++) begin
      e = 8'($urandom);
      p = 8'($urandom);
      pin_in = p;
      pin_dir_in = 8'($urandom);
      plci_host_inst.write_reg(k[0] ? PLCI_ADDR_PORT : PLCI_ADDR_LATCH, e);
      plci_host_inst.read_reg(PLCI_ADDR_LATCH, 1'b1, d);
      chk("latch", d, e);
      chk("pin_out", pin_out, e);
      chk("pin_oe", pin_oe, ~pin_dir_in);
      plci_host_inst.read_reg(PLCI_ADDR_PORT, 1'b1, d);
      chk("port", d, p);
    end
    plci_host_inst.write_reg(PLCI_ADDR_FLAG, 8'hFF);
    plci_host_inst.read_reg(PLCI_ADDR_FLAG, 1'b1, d);
    chk("flag_ro", d, 8'h00);
    plci_host_inst.read_reg(8'h1F, 1'b1, d);
    chk("unmapped", d, 8'h00);
    // --------------------------------------------------------------
    // Previous-value mode
    // --------------------------------------------------------------
    pin_dir_in = 8'hFF;
    change_enable_mask = 8'hFF;
    plci_host_inst.write_reg(PLCI_ADDR_CMP_SEL, 8'h00);
    for (k = 0; k < 8; k++) begin
      j = (k + 3) % 8;
      p = pin_in ^ (8'h01 << k);
      pin_in = p;
      repeat (2) @(negedge clk);
      chk_irq(1'b1);
      pin_in = pin_in ^ (8'h01 << j);
      repeat (2) @(negedge clk);
      plci_host_inst.read_reg(PLCI_ADDR_FLAG, 1'b1, d);
      chk("flag", d, (8'h01 << k) | (8'h01 << j));
      plci_host_inst.write_reg(PLCI_ADDR_CAPTURE, 8'hA5);
      plci_host_inst.write_reg(PLCI_ADDR_PORT, pin_out);
      chk_irq(1'b1);
      plci_host_inst.read_reg(PLCI_ADDR_CAPTURE, 1'b0, d);
      chk_irq(1'b1);
      chk("capture", d, p);
      plci_host_inst.read_reg(k[0] ? PLCI_ADDR_PORT : PLCI_ADDR_CAPTURE, 1'b1, d);
      chk("clear_rd", d, k[0] ? pin_in : p);
      chk_irq(1'b0);
      repeat (3) @(negedge clk);
      chk_irq(1'b0);
    end
    // Output pins and a masked input pin toggling must neither interrupt nor disturb the capture.
    pin_dir_in = 8'h0F;
    change_enable_mask = 8'hFE;
    pin_in = pin_in ^ 8'hF1;
    repeat (2) @(negedge clk);
    chk_irq(1'b0);
    plci_host_inst.read_reg(PLCI_ADDR_FLAG, 1'b1, d);
    chk("flag_masked", d, 8'h00);
    plci_host_inst.read_reg(PLCI_ADDR_CAPTURE, 1'b0, d);
    chk("cap_hold", d, p);
    // --------------------------------------------------------------
    // Compare-to-default mode and pin polarity options
    // --------------------------------------------------------------
    pin_dir_in = 8'hFF;
    change_enable_mask = 8'hFF;
    default_value_register = pin_in;
    plci_host_inst.write_reg(PLCI_ADDR_CMP_SEL, 8'hFF);
    plci_host_inst.read_reg(PLCI_ADDR_CMP_SEL, 1'b1, d);
    chk("cmp_sel", d, 8'hFF);
    for (k = 0; k < 8; k++) begin
      cfg_v = 8'((k % 4) * 2) | (8'($urandom) & ~PLCI_CFG_MASK);
      plci_host_inst.write_reg(PLCI_ADDR_DEV_CFG, cfg_v);
      plci_host_inst.read_reg(PLCI_ADDR_DEV_CFG, 1'b1, d);
      chk("dev_cfg", d, cfg_v & PLCI_CFG_MASK);
      chk_irq(1'b0);
      p = pin_in ^ (8'h01 << k);
      pin_in = p;
      repeat (2) @(negedge clk);
      chk_irq(1'b1);
      plci_host_inst.read_reg(k[0] ? PLCI_ADDR_PORT : PLCI_ADDR_CAPTURE, 1'b1, d);
      chk("dflt_rd", d, p);
      chk_irq(1'b1);
      pin_in = default_value_register;
      repeat (2) @(negedge clk);
      plci_host_inst.read_reg(PLCI_ADDR_CAPTURE, 1'b1, d);
      chk("recapture", d, p);
      chk_irq(1'b0);
    end
    finish_test();
  end
endmodule
